// File: core/asc_defs.svh
// Timing and layout constants for the asynchronous static memory host port
`ifndef ASC_DEFS_SVH
`define ASC_DEFS_SVH

`define ASC_CLK_PERIOD_PS      20000
`define ASC_ADDR_W             19
`define ASC_DATA_W             8
`define ASC_WORDS              524288
`define ASC_T_CYCLE_PS         45000
`define ASC_T_WP_PS            35000
`define ASC_T_DW_PS            25000
`define ASC_T_FLOAT_PS         18000
`define ASC_T_ACCESS_PS        45000
`define ASC_T_OE_PS            22000
`define ASC_T_RET_EXIT_MS      5
`define ASC_PS_PER_MS          1000000000
`define ASC_CYC_UP(t)          (((t) + `ASC_CLK_PERIOD_PS - 1) / `ASC_CLK_PERIOD_PS)
`define ASC_CYC_WP             `ASC_CYC_UP(`ASC_T_WP_PS)
`define ASC_CYC_CYCLE          `ASC_CYC_UP(`ASC_T_CYCLE_PS)
`define ASC_CYC_FLOAT          `ASC_CYC_UP(`ASC_T_FLOAT_PS)
`define ASC_CYC_ACCESS         `ASC_CYC_UP(`ASC_T_ACCESS_PS)
`define ASC_CYC_RET_EXIT \
	((64'd`ASC_T_RET_EXIT_MS * 64'd`ASC_PS_PER_MS + 64'd`ASC_CLK_PERIOD_PS - 64'd1) \
	/ 64'd`ASC_CLK_PERIOD_PS)
`define ASC_CNT_W              18
`define ASC_CNT_ONE            18'h0_0001
`define ASC_CNT_ZERO           18'h0_0000

`endif

// File: core/asc_pkg.sv
// Types shared by the asynchronous static memory host port
package asc_pkg;

	typedef struct packed
	{
		logic        write;
		logic [18:0] index;
		logic [7:0]  data;
	} asc_req_type;

	typedef struct packed
	{
		logic       select_n;
		logic       strobe_n;
		logic       drive_n;
	} asc_ctl_type;

	typedef enum logic [2:0]
	{
		ASC_RECOVER,
		ASC_IDLE,
		ASC_RD_ACCESS,
		ASC_WR_FLOAT,
		ASC_WR_PULSE,
		ASC_GAP,
		ASC_RETAIN
	} asc_state_type;

endpackage : asc_pkg

// File: core/asc_timer.sv
// Loadable down-counter that marks the end of a timed interval
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"

module asc_timer #(
	parameter int W = `ASC_CNT_W
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	input  wire logic         load,
	input  wire logic [W-1:0] value,
	output logic              done
);

	logic [W-1:0] count_reg;

	always_ff @(posedge clk)
	begin
		if (rst)
			count_reg <= '0;
		else if (ce)
		begin
			if (load)
				count_reg <= value;
			else if (count_reg != '0)
				count_reg <= count_reg - W'(1);
		end
	end

	// Done once the count reaches one, so a load of N lasts N cycles
	// Done must not look at load: the sequencer loads on done
	assign done = count_reg <= W'(1);

endmodule : asc_timer
`default_nettype wire

// File: core/asc_host.sv
// Clocked host controller for an asynchronous 512K x 8 static memory
// Operation
// - Host drives bus only when memory floats
// - Write starts when select and strobe low
// - Write ends when select or strobe rises
// - Write pulse at least 35 ns
// - Write cycle 45 ns, address 35 ns before end
// - Select held 35 ns before write end
// - Address may change at write start, end
// - Data valid 25 ns before write end
// - Host waits 18 ns float after write start
// - Deselect 5 ms after retention exit
`timescale 1ns/1ps
`default_nettype none
`include "asc_defs.svh"

module asc_host #(
	parameter int ADDR_W       = `ASC_ADDR_W,
	parameter int DATA_W       = `ASC_DATA_W,
	parameter int CYC_RET_EXIT = int'(`ASC_CYC_RET_EXIT)
) (
	// Clock and reset
	input  wire logic              CLOCK,
	input  wire logic              RESET,
	input  wire logic              CE,
	// User request port
	input  wire logic              REQ_VALID,
	input  wire logic              REQ_WRITE,
	input  wire logic [ADDR_W-1:0] REQ_INDEX,
	input  wire logic [DATA_W-1:0] REQ_DATA,
	output logic                   REQ_READY,
	output logic                   RD_VALID,
	output logic [DATA_W-1:0]      RD_DATA,
	// Retention control
	input  wire logic              RETAIN,
	output logic                   RETAINED,
	// Memory pins
	output logic [ADDR_W-1:0]      WORD_INDEX_LINES,
	input  wire logic [DATA_W-1:0] BYTE_BUS_LINES_IN,
	output logic [DATA_W-1:0]      BYTE_BUS_LINES_OUT,
	output logic                   BYTE_BUS_LINES_OE,
	output logic                   CHIP_SELECT_N,
	output logic                   WRITE_STROBE_N,
	output logic                   OUTPUT_DRIVE_N
);

	localparam logic [`ASC_CNT_W-1:0] CYC_WP     = `ASC_CNT_W'(`ASC_CYC_WP);
	localparam logic [`ASC_CNT_W-1:0] CYC_FLOAT  = `ASC_CNT_W'(`ASC_CYC_FLOAT);
	localparam logic [`ASC_CNT_W-1:0] CYC_ACCESS = `ASC_CNT_W'(`ASC_CYC_ACCESS);
	localparam logic [`ASC_CNT_W-1:0] CYC_CYCLE  = `ASC_CNT_W'(`ASC_CYC_CYCLE);
	localparam logic [`ASC_CNT_W-1:0] CYC_GAP    = `ASC_CNT_W'(`ASC_CYC_FLOAT);
	localparam logic [`ASC_CNT_W-1:0] CYC_RET    = `ASC_CNT_W'(CYC_RET_EXIT);

	asc_pkg::asc_state_type   state_reg;
	asc_pkg::asc_req_type     req_reg;
	asc_pkg::asc_ctl_type     ctl_next;
	logic                     load;
	logic [`ASC_CNT_W-1:0]    load_value;
	logic                     done;

	//------------------------------------------------------------
	// Interval timer
	//------------------------------------------------------------
	asc_timer #(
		.W     (`ASC_CNT_W)
	) u_timer (
		.clk   (CLOCK),
		.rst   (RESET),
		.ce    (CE),
		.load  (load),
		.value (load_value),
		.done  (done)
	);

	//------------------------------------------------------------
	// Sequencer
	//------------------------------------------------------------
	always_comb
	begin
		load       = 1'b0;
		load_value = `ASC_CNT_ZERO;
		unique case (state_reg)
			asc_pkg::ASC_RECOVER:
			begin
				load = 1'b0;
			end
			asc_pkg::ASC_IDLE:
			begin
				if (RETAIN)
				begin
					load       = 1'b0;
				end
				else if (REQ_VALID)
				begin
					load       = 1'b1;
					// Read adds a cycle because select lags the state by one register
					load_value = REQ_WRITE ? CYC_FLOAT
						: CYC_ACCESS + `ASC_CNT_ONE;
				end
			end
			asc_pkg::ASC_RD_ACCESS:
			begin
				if (done)
				begin
					load       = 1'b1;
					load_value = CYC_GAP;
				end
			end
			asc_pkg::ASC_WR_FLOAT:
			begin
				if (done)
				begin
					load       = 1'b1;
					// Pulse covers 35 ns width, address and select before end
					load_value = (CYC_WP > CYC_CYCLE - CYC_FLOAT) ? CYC_WP
						: CYC_CYCLE - CYC_FLOAT;
				end
			end
			asc_pkg::ASC_WR_PULSE:
			begin
				if (done)
				begin
					load       = 1'b1;
					load_value = `ASC_CNT_ONE;
				end
			end
			asc_pkg::ASC_GAP:
			begin
				load = 1'b0;
			end
			asc_pkg::ASC_RETAIN:
			begin
				if (!RETAIN)
				begin
					load       = 1'b1;
					load_value = CYC_RET;
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK)
	begin
		if (RESET)
			state_reg <= asc_pkg::ASC_IDLE;
		else if (CE)
		begin
			unique case (state_reg)
				asc_pkg::ASC_RECOVER:
					if (done)
						state_reg <= asc_pkg::ASC_IDLE;
				asc_pkg::ASC_IDLE:
					if (RETAIN)
						state_reg <= asc_pkg::ASC_RETAIN;
					else if (REQ_VALID)
						state_reg <= REQ_WRITE ? asc_pkg::ASC_WR_FLOAT
							: asc_pkg::ASC_RD_ACCESS;
				asc_pkg::ASC_RD_ACCESS:
					if (done)
						state_reg <= asc_pkg::ASC_GAP;
				asc_pkg::ASC_WR_FLOAT:
					if (done)
						state_reg <= asc_pkg::ASC_WR_PULSE;
				asc_pkg::ASC_WR_PULSE:
					if (done)
						state_reg <= asc_pkg::ASC_GAP;
				asc_pkg::ASC_GAP:
					if (done)
						state_reg <= asc_pkg::ASC_IDLE;
				asc_pkg::ASC_RETAIN:
					if (!RETAIN)
						state_reg <= asc_pkg::ASC_RECOVER;
			endcase
		end
	end

	//------------------------------------------------------------
	// Request capture
	//------------------------------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
			req_reg <= '0;
		else if (CE && state_reg == asc_pkg::ASC_IDLE && REQ_VALID && !RETAIN)
			req_reg <= '{write: REQ_WRITE, index: REQ_INDEX, data: REQ_DATA};
	end

	//------------------------------------------------------------
	// Pin drive, all registered
	//------------------------------------------------------------
	always_comb
	begin
		ctl_next = '{select_n: 1'b1, strobe_n: 1'b1, drive_n: 1'b1};
		unique case (state_reg)
			asc_pkg::ASC_RD_ACCESS:
				ctl_next = '{select_n: 1'b0, strobe_n: 1'b1, drive_n: 1'b0};
			asc_pkg::ASC_WR_FLOAT:
				ctl_next = '{select_n: 1'b0, strobe_n: 1'b0, drive_n: 1'b1};
			asc_pkg::ASC_WR_PULSE:
				// Pins lag the state, so the strobe rises one cycle after the pulse state ends
				ctl_next = '{select_n: 1'b0, strobe_n: 1'b0, drive_n: 1'b1};
			default:
				ctl_next = '{select_n: 1'b1, strobe_n: 1'b1, drive_n: 1'b1};
		endcase
	end

	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			CHIP_SELECT_N  <= 1'b1;
			WRITE_STROBE_N <= 1'b1;
			OUTPUT_DRIVE_N <= 1'b1;
		end
		else if (CE)
		begin
			CHIP_SELECT_N  <= ctl_next.select_n;
			WRITE_STROBE_N <= ctl_next.strobe_n;
			OUTPUT_DRIVE_N <= ctl_next.drive_n;
		end
	end

	always_ff @(posedge CLOCK)
	begin
		if (RESET)
			WORD_INDEX_LINES <= '0;
		else if (CE && state_reg == asc_pkg::ASC_IDLE && REQ_VALID && !RETAIN)
			WORD_INDEX_LINES <= REQ_INDEX;
	end

	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			BYTE_BUS_LINES_OE  <= 1'b0;
			BYTE_BUS_LINES_OUT <= '0;
		end
		else if (CE)
		begin
			// Drive only after the float wait, release at write end
			BYTE_BUS_LINES_OE  <= state_reg == asc_pkg::ASC_WR_PULSE;
			BYTE_BUS_LINES_OUT <= req_reg.data;
		end
	end

	//------------------------------------------------------------
	// Handshake and read data
	//------------------------------------------------------------
	always_ff @(posedge CLOCK)
	begin
		if (RESET)
		begin
			REQ_READY <= 1'b0;
			RD_VALID  <= 1'b0;
			RD_DATA   <= '0;
			RETAINED  <= 1'b0;
		end
		else if (CE)
		begin
			REQ_READY <= (state_reg == asc_pkg::ASC_GAP && done)
				|| (state_reg == asc_pkg::ASC_IDLE && !(REQ_VALID || RETAIN));
			RD_VALID  <= state_reg == asc_pkg::ASC_RD_ACCESS && done;
			if (state_reg == asc_pkg::ASC_RD_ACCESS && done)
				RD_DATA <= BYTE_BUS_LINES_IN;
			RETAINED  <= state_reg == asc_pkg::ASC_RETAIN && RETAIN;
		end
	end

endmodule : asc_host
`default_nettype wire

// File: tb/asc_host_asserts.sv
// Pin timing checks for the static memory host port
`timescale 1ns/1ps
`default_nettype none
module asc_host_asserts (
	// Clock and reset
	input wire logic        CLOCK,
	input wire logic        RESET,
	// Observed outputs
	input wire logic        RD_VALID,
	input wire logic        RETAINED,
	input wire logic [18:0] WORD_INDEX_LINES,
	input wire logic        BYTE_BUS_LINES_OE,
	input wire logic        CHIP_SELECT_N,
	input wire logic        WRITE_STROBE_N,
	input wire logic        OUTPUT_DRIVE_N
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	a_host_drive_legal: assert property (BYTE_BUS_LINES_OE |-> !WRITE_STROBE_N && OUTPUT_DRIVE_N)
		else $error("host drives bus outside a write");
	a_float_wait: assert property ($fell(WRITE_STROBE_N) |-> !BYTE_BUS_LINES_OE)
		else $error("host drives bus at write start");
	a_start_pair: assert property ($fell(WRITE_STROBE_N) |-> $fell(CHIP_SELECT_N))
		else $error("write start not paired");
	a_end_pair: assert property ($rose(WRITE_STROBE_N) |-> $rose(CHIP_SELECT_N))
		else $error("write end not paired");
	a_pulse_width: assert property ($fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N [*2])
		else $error("write pulse short");
	a_select_before_end: assert property ($rose(WRITE_STROBE_N) |-> !$past(CHIP_SELECT_N, 2))
		else $error("select short before write end");
	a_data_before_end: assert property ($rose(WRITE_STROBE_N) |-> $past(BYTE_BUS_LINES_OE, 2))
		else $error("write data late");
	a_index_steady: assert property (!WRITE_STROBE_N && !$past(WRITE_STROBE_N) |-> $stable(WORD_INDEX_LINES))
		else $error("index moved in write");
	a_cycle_gap: assert property ($rose(CHIP_SELECT_N) |-> CHIP_SELECT_N [*2])
		else $error("cycle spacing short");
	a_read_access: assert property ($rose(RD_VALID) |-> !$past(CHIP_SELECT_N, 3) && !$past(OUTPUT_DRIVE_N, 3))
		else $error("read sampled too early");
	a_retain_idle: assert property (RETAINED |-> CHIP_SELECT_N && WRITE_STROBE_N)
		else $error("selected in retention");
endmodule : asc_host_asserts
bind asc_host asc_host_asserts u_chk (.CLOCK(CLOCK), .RESET(RESET), .RD_VALID(RD_VALID),
	.RETAINED(RETAINED), .WORD_INDEX_LINES(WORD_INDEX_LINES),
	.BYTE_BUS_LINES_OE(BYTE_BUS_LINES_OE), .CHIP_SELECT_N(CHIP_SELECT_N),
	.WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_DRIVE_N(OUTPUT_DRIVE_N));
`default_nettype wire

// File: tb/asc_sram_model.sv
// Behavioural asynchronous static memory on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module asc_sram_model (
	// Memory pins
	input wire logic [18:0] index,
	input wire logic        select_n,
	input wire logic        strobe_n,
	input wire logic        drive_n,
	// Host side of the byte bus
	input wire logic [7:0]  host_data,
	input wire logic        host_oe,
	output logic [7:0]      bus
);
	logic [7:0] mem [0:524287];
	logic [7:0] dq;
	logic [7:0] seen;
	logic [7:0] bus_d;
	logic       drv;
	wire        rd = !select_n && strobe_n && !drive_n;
	wire        wr = !select_n && !strobe_n;
	initial
	begin
		drv = 1'b0;
		dq = 8'h00;
		seen = 8'h00;
	end
	// Output buffer turns on early and lets go at the last moment
	always @(rd)
		if (rd)
			drv <= #10 1'b1;
		else
			drv <= #18 1'b0;
	// Old byte holds briefly, then garbage until the access time
	always @(negedge select_n, index)
	begin
		dq <= #10 ~dq;
		dq <= #45 mem[index];
	end
	always @(bus)
		bus_d <= #1 bus;
	always @(negedge wr)
		mem[index] = bus_d;
	always @(bus)
		if (host_oe || drv)
			seen = bus;
	assign bus = (host_oe && drv) ? 8'hxx : host_oe ? host_data : drv ? dq : ~seen;
endmodule : asc_sram_model
`default_nettype wire

// File: tb/test_asc_host.sv
// Self-checking bench for the static memory host port
`timescale 1ns/1ps
`default_nettype none
module test_asc_host;
	logic        CLOCK, RESET, REQ_VALID, REQ_WRITE, RETAIN;
	logic [18:0] REQ_INDEX, WORD_INDEX_LINES;
	logic [7:0]  REQ_DATA, RD_DATA, bus, bus_out;
	logic        REQ_READY, RD_VALID, RETAINED, bus_oe;
	logic        CHIP_SELECT_N, WRITE_STROBE_N, OUTPUT_DRIVE_N;
	int          fails = 0;
	int          cmp_count = 0;
	asc_host #(.CYC_RET_EXIT(10)) uut (.CLOCK(CLOCK), .RESET(RESET), .CE(1'b1),
		.REQ_VALID(REQ_VALID), .REQ_WRITE(REQ_WRITE), .REQ_INDEX(REQ_INDEX),
		.REQ_DATA(REQ_DATA), .REQ_READY(REQ_READY), .RD_VALID(RD_VALID),
		.RD_DATA(RD_DATA), .RETAIN(RETAIN), .RETAINED(RETAINED),
		.WORD_INDEX_LINES(WORD_INDEX_LINES), .BYTE_BUS_LINES_IN(bus),
		.BYTE_BUS_LINES_OUT(bus_out), .BYTE_BUS_LINES_OE(bus_oe),
		.CHIP_SELECT_N(CHIP_SELECT_N), .WRITE_STROBE_N(WRITE_STROBE_N),
		.OUTPUT_DRIVE_N(OUTPUT_DRIVE_N));
	asc_sram_model mem (.index(WORD_INDEX_LINES), .select_n(CHIP_SELECT_N),
		.strobe_n(WRITE_STROBE_N), .drive_n(OUTPUT_DRIVE_N), .host_data(bus_out),
		.host_oe(bus_oe), .bus(bus));
	initial
	begin
		CLOCK = 1'b0;
		forever #10 CLOCK = ~CLOCK;
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task report_and_stop;
		if (fails == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	task put(input logic w, input logic [18:0] i, input logic [7:0] d);
		int n;
		n = 0;
		while (REQ_READY !== 1'b1 && n < 50)
		begin
			@(negedge CLOCK);
			n++;
		end
		chk("ready", 8'h01, 8'(REQ_READY));
		REQ_VALID = 1'b1;
		REQ_WRITE = w;
		REQ_INDEX = i;
		REQ_DATA = d;
		@(negedge CLOCK);
		REQ_VALID = 1'b0;
	endtask : put
	task rd_wait(input logic [7:0] e);
		int n;
		n = 0;
		while (RD_VALID !== 1'b1 && n < 12)
		begin
			@(negedge CLOCK);
			n++;
		end
		chk("rd_valid", 8'h01, 8'(RD_VALID));
		chk("rd_data", e, RD_DATA);
	endtask : rd_wait
	task t_reset;
		chk("strobes", 8'h07, {5'h00, CHIP_SELECT_N, WRITE_STROBE_N, OUTPUT_DRIVE_N});
		chk("bus_oe", 8'h00, 8'(bus_oe));
	endtask : t_reset
	task t_edges;
		logic [18:0] ia [3];
		logic [7:0]  da [3];
		ia = '{19'h0_0000, 19'h7_FFFF, 19'h2_AAAA};
		da = '{8'h5A, 8'hA5, 8'hFF};
		for (int k = 0; k < 3; k++)
			put(1'b1, ia[k], da[k]);
		for (int k = 2; k >= 0; k--)
		begin
			put(1'b0, ia[k], 8'h00);
			rd_wait(da[k]);
		end
	endtask : t_edges
	task t_overwrite;
		put(1'b1, 19'h0_0123, 8'h11);
		put(1'b1, 19'h0_0123, 8'h00);
		put(1'b0, 19'h0_0123, 8'h00);
		rd_wait(8'h00);
	endtask : t_overwrite
	task t_retain;
		int n;
		put(1'b1, 19'h1_2345, 8'hC3);
		put(1'b0, 19'h1_2345, 8'h00);
		rd_wait(8'hC3);
		RETAIN = 1'b1;
		repeat (8) @(negedge CLOCK);
		chk("retained", 8'h01, 8'(RETAINED));
		REQ_VALID = 1'b1;
		REQ_WRITE = 1'b0;
		repeat (4) @(negedge CLOCK);
		chk("cs_held", 8'h01, 8'(CHIP_SELECT_N));
		RETAIN = 1'b0;
		n = 0;
		while (CHIP_SELECT_N !== 1'b0 && n < 100)
		begin
			@(negedge CLOCK);
			n++;
		end
		chk("exit_wait", 8'h01, 8'(n >= 10 && n < 100));
		REQ_VALID = 1'b0;
		rd_wait(8'hC3);
	endtask : t_retain
	initial
	begin
		RESET = 1'b1;
		REQ_VALID = 1'b0;
		REQ_WRITE = 1'b0;
		REQ_INDEX = 19'h0_0000;
		REQ_DATA = 8'h00;
		RETAIN = 1'b0;
		repeat (3) @(negedge CLOCK);
		RESET = 1'b0;
		t_reset;
		t_edges;
		t_overwrite;
		t_retain;
		report_and_stop;
	end
	initial
	begin
		#40000;
		fails++;
		report_and_stop;
	end
endmodule : test_asc_host
`default_nettype wire
